// ==== dbtc_map.vh ====
// Purpose: register offsets, field positions and reset values of the dual byte timer
// Assumes: apb byte addresses, one aligned word per register
// Notes: offsets are printed indices times four
`ifndef DBTC_MAP_VH
`define DBTC_MAP_VH
`define DBTC_IDX_CONTROL 16'hFE10
`define DBTC_IDX_PRESCALE 16'hFE11
`define DBTC_IDX_LOW_COUNT 16'hFE12
`define DBTC_IDX_HIGH_COUNT 16'hFE13
`define DBTC_IDX_LOW_MATCH 16'hFE14
`define DBTC_IDX_HIGH_MATCH 16'hFE15
`define DBTC_IDX_LOW_CAPTURE 16'hFE16
`define DBTC_IDX_HIGH_CAPTURE 16'hFE17
`define DBTC_IDX_LOW_CAPTURE2 16'hFE1E
`define DBTC_IDX_HIGH_CAPTURE2 16'hFE1F
`define DBTC_IDX_INPUT_SELECT 16'hFE20
`define DBTC_ADDR_W 18
`define DBTC_BIT_HIGH_RUN 7
`define DBTC_BIT_LOW_RUN 6
`define DBTC_BIT_LONG_MODE 5
`define DBTC_BIT_LOW_EXT 4
`define DBTC_BIT_HIGH_FLAG 3
`define DBTC_BIT_HIGH_IE 2
`define DBTC_BIT_LOW_FLAG 1
`define DBTC_BIT_LOW_IE 0
`define DBTC_BIT_SEL_HCAP 7
`define DBTC_BIT_SEL_LCAP 6
`define DBTC_BIT_SEL_CNT 0
`define DBTC_RST_BYTE 8'h00
`define DBTC_ONE_BYTE 8'h01
`define DBTC_FULL_BYTE 8'hFF
`endif

// ==== dbtc_prescaler.v ====
// Purpose: 8-bit programmable prescaler of the cycle clock
// Assumes: pclk is the cycle clock
// Notes: restart on a limit write overrides a match
`timescale 1ns/1ps
`include "dbtc_map.vh"
module dbtc_prescaler (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire hold_mode,
    input wire [7:0] limit,
    input wire limit_wr,
    output wire tick
);
    reg [7:0] count_ff;
    reg [7:0] nxt_count;
    assign tick = clk_en && !hold_mode && !limit_wr && (count_ff == limit);
    // next count
    always @* begin
        nxt_count = count_ff;
        if (limit_wr) begin
            nxt_count = `DBTC_RST_BYTE;
        end else if (hold_mode) begin
            nxt_count = count_ff;
        end else if (count_ff == limit) begin
            nxt_count = `DBTC_RST_BYTE;
        end else begin
            nxt_count = count_ff + `DBTC_ONE_BYTE;
        end
    end
    // counter state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= `DBTC_RST_BYTE;
        end else if (clk_en) begin
            count_ff <= nxt_count;
        end
    end
endmodule

// ==== dbtc_half.v ====
// Purpose: one 8-bit counter half with match buffer
// Assumes: count pulse one cycle wide
// Notes: match compare is supplied from outside so halves can chain
`timescale 1ns/1ps
`include "dbtc_map.vh"
module dbtc_half (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire run,
    input wire count_pulse,
    input wire match_clear,
    input wire [7:0] match_data,
    output wire [7:0] count,
    output wire [7:0] buffer,
    output wire equal
);
    reg [7:0] count_ff;
    reg [7:0] buffer_ff;
    assign count = count_ff;
    assign buffer = buffer_ff;
    assign equal = (count_ff == buffer_ff);
    // count and match buffer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= `DBTC_RST_BYTE;
            buffer_ff <= `DBTC_RST_BYTE;
        end else if (clk_en) begin
            if (!run) begin
                count_ff <= `DBTC_RST_BYTE;
                buffer_ff <= match_data;
            end else if (match_clear) begin
                count_ff <= `DBTC_RST_BYTE;
                buffer_ff <= match_data;
            end else if (count_pulse) begin
                count_ff <= count_ff + `DBTC_ONE_BYTE;
            end
        end
    end
endmodule

// ==== dbtc_top.v ====
// Purpose: dual byte timer counter with apb register access
// Assumes: detection pulses come from external edge logic, one cycle each
// Notes: pready is registered high for the access phase, pslverr on unmapped address
//        16-bit modes chain the bytes by low byte rollover, so the pair is one word
//        match buffers reload only through the half that owns them
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "dbtc_map.vh"
module dbtc_top (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`DBTC_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire hold_mode,
    input wire ext_irq_two,
    input wire ext_irq_three,
    input wire ext_irq_zero,
    input wire ext_irq_one,
    input wire port_low_capture,
    input wire port_high_capture,
    output reg low_irq_req,
    output reg high_irq_req
);
    reg [7:0] control_ff;
    reg [7:0] prescale_ff;
    reg [7:0] low_data_ff;
    reg [7:0] high_data_ff;
    reg [7:0] low_cap_ff;
    reg [7:0] high_cap_ff;
    reg [7:0] low_cap2_ff;
    reg [7:0] high_cap2_ff;
    reg [7:0] select_ff;
    reg [31:0] nxt_prdata;
    reg nxt_pslverr;
    wire [7:0] low_count;
    wire [7:0] high_count;
    wire low_eq;
    wire high_eq;
    wire tick;
    wire wr;
    wire wr_pre;
    wire wr_low_data;
    wire wr_high_data;
    wire wr_sel;
    wire low_carry;
    wire low_full_eq;
    wire nxt_low_ie;
    wire nxt_high_ie;
    wire [15:0] idx;
    wire low_run;
    wire high_run;
    wire long_mode;
    wire low_ext;
    wire ext_event;
    wire low_pulse;
    wire high_pulse;
    wire low_match;
    wire high_match;
    wire low_cap_evt;
    wire high_cap_evt;
    wire ctl_wr;
    reg nxt_low_flag;
    reg nxt_high_flag;

    // apb decode; a write lands only at the edge that also sees pready
    assign wr = psel && penable && pready && pwrite && clk_en;
    assign idx = paddr[17:2];
    assign ctl_wr = wr && (idx == `DBTC_IDX_CONTROL);
    // one strobe per writable byte, so the prescaler restart sees the same decode
    assign wr_pre = wr && (idx == `DBTC_IDX_PRESCALE);
    assign wr_low_data = wr && (idx == `DBTC_IDX_LOW_MATCH);
    assign wr_high_data = wr && (idx == `DBTC_IDX_HIGH_MATCH);
    assign wr_sel = wr && (idx == `DBTC_IDX_INPUT_SELECT);

    // control fields
    assign high_run = control_ff[`DBTC_BIT_HIGH_RUN];
    assign low_run = control_ff[`DBTC_BIT_LOW_RUN];
    assign long_mode = control_ff[`DBTC_BIT_LONG_MODE];
    assign low_ext = control_ff[`DBTC_BIT_LOW_EXT];

    // external count source picked by the select register
    assign ext_event = select_ff[`DBTC_BIT_SEL_CNT] ? ext_irq_three : ext_irq_two;
    assign low_pulse = low_ext ? ext_event : tick;
    // match generation: 16-bit mode needs both bytes equal
    assign low_full_eq = low_eq && high_eq;
    assign low_match = low_run && low_pulse && (long_mode ? low_full_eq : low_eq);
    // long mode: low byte rolls over at ff so the pair counts as one word;
    // wrapping it on its own buffer would give (low+1)*(high+1), not word+1
    assign low_carry = low_run && low_pulse && (low_count == `DBTC_FULL_BYTE);
    assign high_pulse = long_mode ? low_carry : tick;
    assign high_match = long_mode ? (high_run && low_match) :
        (high_run && high_pulse && high_eq);
    // capture sources; pins routed by the select register
    assign high_cap_evt = port_high_capture ||
        (select_ff[`DBTC_BIT_SEL_HCAP] ? ext_irq_one : ext_irq_three);
    assign low_cap_evt = port_low_capture ||
        (select_ff[`DBTC_BIT_SEL_LCAP] ? ext_irq_zero : ext_irq_two);

    // low half: in long mode it rolls over at ff and clears on its buffer only on a full match
    dbtc_half u_low (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .run(low_run),
        .count_pulse(low_pulse), // match_clear has priority inside the half
        .match_clear(low_match),
        .match_data(low_data_ff),
        .count(low_count),
        .buffer(),
        .equal(low_eq)
    );

    // high half
    dbtc_half u_high (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .run(high_run),
        .count_pulse(high_pulse),
        .match_clear(high_match),
        .match_data(high_data_ff),
        .count(high_count),
        .buffer(),
        .equal(high_eq)
    );

    // prescaler, shared by both halves
    dbtc_prescaler u_pre (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .hold_mode(hold_mode),
        .limit(prescale_ff),
        .limit_wr(wr_pre),
        .tick(tick)
    );

    // match flags: hardware set wins over a software clear in the same cycle
    always @* begin
        nxt_low_flag = control_ff[`DBTC_BIT_LOW_FLAG];
        nxt_high_flag = control_ff[`DBTC_BIT_HIGH_FLAG];
        if (ctl_wr) begin
            nxt_low_flag = pwdata[`DBTC_BIT_LOW_FLAG];
            nxt_high_flag = pwdata[`DBTC_BIT_HIGH_FLAG];
        end
        if (long_mode ? high_match : low_match) begin
            nxt_low_flag = 1'b1;
        end
        if (high_match) begin
            nxt_high_flag = 1'b1;
        end
    end

    // control byte; flag bits take the merged hardware and software value
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_ff <= `DBTC_RST_BYTE;
        end else if (clk_en) begin
            if (ctl_wr) begin
                control_ff <= pwdata[7:0];
            end
            control_ff[`DBTC_BIT_LOW_FLAG] <= nxt_low_flag;
            control_ff[`DBTC_BIT_HIGH_FLAG] <= nxt_high_flag;
        end
    end

    // prescale limit
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_ff <= `DBTC_RST_BYTE;
        end else if (wr_pre) begin
            prescale_ff <= pwdata[7:0];
        end
    end

    // low match data; the buffer inside the half decides when it is used
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_data_ff <= `DBTC_RST_BYTE;
        end else if (wr_low_data) begin
            low_data_ff <= pwdata[7:0];
        end
    end

    // high match data
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_data_ff <= `DBTC_RST_BYTE;
        end else if (wr_high_data) begin
            high_data_ff <= pwdata[7:0];
        end
    end

    // input select; changing it mid-count may give one stray event
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            select_ff <= `DBTC_RST_BYTE;
        end else if (wr_sel) begin
            select_ff <= pwdata[7:0];
        end
    end

    // capture registers; second pair keeps the previous capture
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cap_ff <= `DBTC_RST_BYTE;
            high_cap_ff <= `DBTC_RST_BYTE;
            low_cap2_ff <= `DBTC_RST_BYTE;
            high_cap2_ff <= `DBTC_RST_BYTE;
        end else if (clk_en) begin
            if (long_mode) begin
                if (high_cap_evt) begin
                    low_cap_ff <= low_count;
                    high_cap_ff <= high_count;
                    low_cap2_ff <= low_cap_ff;
                    high_cap2_ff <= high_cap_ff;
                end
            end else begin
                if (low_cap_evt) begin
                    low_cap_ff <= low_count;
                    low_cap2_ff <= low_cap_ff;
                end
                if (high_cap_evt) begin
                    high_cap_ff <= high_count;
                    high_cap2_ff <= high_cap_ff;
                end
            end
        end
    end

    // enables as they stand after this edge, so a request drops with its enable
    assign nxt_low_ie = ctl_wr ? pwdata[`DBTC_BIT_LOW_IE] : control_ff[`DBTC_BIT_LOW_IE];
    assign nxt_high_ie = ctl_wr ? pwdata[`DBTC_BIT_HIGH_IE] : control_ff[`DBTC_BIT_HIGH_IE];

    // interrupt requests follow flag and enable
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_irq_req <= 1'b0;
            high_irq_req <= 1'b0;
        end else if (clk_en) begin
            low_irq_req <= nxt_low_flag && nxt_low_ie;
            high_irq_req <= nxt_high_flag && nxt_high_ie;
        end
    end

    // read mux, registered in the setup cycle so the access phase sees it
    always @* begin
        nxt_prdata = 32'h00000000;
        nxt_pslverr = 1'b0;
        if (idx == `DBTC_IDX_CONTROL) begin
            nxt_prdata[7:0] = control_ff;
        end else if (idx == `DBTC_IDX_PRESCALE) begin
            nxt_prdata[7:0] = prescale_ff;
        end else if (idx == `DBTC_IDX_LOW_COUNT) begin
            nxt_prdata[7:0] = low_count;
        end else if (idx == `DBTC_IDX_HIGH_COUNT) begin
            nxt_prdata[7:0] = high_count;
        end else if (idx == `DBTC_IDX_LOW_MATCH) begin
            nxt_prdata[7:0] = low_data_ff;
        end else if (idx == `DBTC_IDX_HIGH_MATCH) begin
            nxt_prdata[7:0] = high_data_ff;
        end else if (idx == `DBTC_IDX_LOW_CAPTURE) begin
            nxt_prdata[7:0] = low_cap_ff;
        end else if (idx == `DBTC_IDX_HIGH_CAPTURE) begin
            nxt_prdata[7:0] = high_cap_ff;
        end else if (idx == `DBTC_IDX_LOW_CAPTURE2) begin
            nxt_prdata[7:0] = low_cap2_ff;
        end else if (idx == `DBTC_IDX_HIGH_CAPTURE2) begin
            nxt_prdata[7:0] = high_cap2_ff;
        end else if (idx == `DBTC_IDX_INPUT_SELECT) begin
            nxt_prdata[7:0] = select_ff;
        end else begin
            nxt_pslverr = 1'b1;
        end
    end

    // bus outputs sampled during setup, held through access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (clk_en && psel && !penable) begin
            prdata <= pwrite ? 32'h00000000 : nxt_prdata;
            pslverr <= nxt_pslverr;
        end
    end

    // ready rises for the access phase only; read data is already latched then
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else if (clk_en) begin
            pready <= psel && !penable;
        end
    end
endmodule

// ==== dbtc_monitor.sv ====
// Purpose: port checker of the dual byte timer
// Assumes: writes land at the access edge, prdata latched at setup
// Notes: shadows the software-written control and limit bytes
`timescale 1ns/1ps
`include "dbtc_map.vh"
module dbtc_monitor (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [17:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire low_irq_req,
    input wire high_irq_req
);
    localparam [17:0] CTL = {`DBTC_IDX_CONTROL, 2'b00};
    localparam [17:0] PRE = {`DBTC_IDX_PRESCALE, 2'b00};
    localparam [17:0] LCNT = {`DBTC_IDX_LOW_COUNT, 2'b00};
    localparam [17:0] HCNT = {`DBTC_IDX_HIGH_COUNT, 2'b00};
    wire acc_wr = psel && penable && pwrite && clk_en;
    wire wr_ctl = acc_wr && paddr == CTL;
    wire rd_set = psel && !penable && !pwrite && clk_en;
    reg [7:0] ctl_ff;
    reg [7:0] pre_ff;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // flag bits shadow only the software write: hardware sets them
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_ff <= 8'h00;
            pre_ff <= 8'h00;
        end else begin
            if (wr_ctl) ctl_ff <= pwdata[7:0];
            if (acc_wr && paddr == PRE) pre_ff <= pwdata[7:0];
        end
    end
    a_low_irq_mask: assert property (!ctl_ff[0] |-> !low_irq_req)
        else $error("low request without enable");
    a_high_irq_mask: assert property (!ctl_ff[2] |-> !high_irq_req)
        else $error("high request without enable");
    a_low_irq_hold: assert property (low_irq_req && !wr_ctl |=> low_irq_req)
        else $error("low request dropped without a write");
    a_high_irq_hold: assert property (high_irq_req && !wr_ctl |=> high_irq_req)
        else $error("high request dropped without a write");
    a_flag_read_back: assert property (rd_set && paddr == CTL && low_irq_req
        |=> prdata[1:0] == 2'b11) else $error("low flag not readable");
    a_limit_read_back: assert property (rd_set && paddr == PRE
        |=> prdata[7:0] == $past(pre_ff)) else $error("limit read mismatch");
    a_low_stop_zero: assert property (rd_set && paddr == LCNT && !ctl_ff[6]
        && !$past(ctl_ff[6]) |=> prdata[7:0] == 8'h00) else $error("stopped low count");
    a_high_stop_zero: assert property (rd_set && paddr == HCNT && !ctl_ff[7]
        && !$past(ctl_ff[7]) |=> prdata[7:0] == 8'h00) else $error("stopped high count");
endmodule

// ==== dbtc_event_src.sv ====
// Purpose: external edge logic in front of the timer
// Assumes: each detection is one pclk cycle wide
// Notes: k 0 gives source two, 1 source three, 2 source zero
`timescale 1ns/1ps
module dbtc_event_src (
    input wire pclk,
    output reg ext_irq_two,
    output reg ext_irq_three,
    output reg ext_irq_zero
);
    initial begin
        ext_irq_two = 1'b0;
        ext_irq_three = 1'b0;
        ext_irq_zero = 1'b0;
    end
    // n separate pulses, a low cycle between them
    task pulses(input int k, input int n);
        repeat (n) begin
            @(posedge pclk);
            ext_irq_two <= (k == 0);
            ext_irq_three <= (k == 1);
            ext_irq_zero <= (k == 2);
            @(posedge pclk);
            ext_irq_two <= 1'b0;
            ext_irq_three <= 1'b0;
            ext_irq_zero <= 1'b0;
        end
    endtask
endmodule

// ==== tb_dual_byte_timer_counter.sv ====
// Purpose: self-checking bench of the dual byte timer
// Assumes: zero wait apb slave, one-cycle detection pulses
// Notes: port capture inputs and the second high capture pin stay idle
`timescale 1ns/1ps
`include "dbtc_map.vh"
module tb_dual_byte_timer_counter;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg hold_mode = 1'b0;
    reg [17:0] paddr = 18'h00000;
    reg [31:0] pwdata = 32'h00000000;
    wire [31:0] prdata;
    wire pready, pslverr, low_irq_req, high_irq_req, ev_two, ev_three, ev_zero;
    int cyc = 0;
    int bad_count = 0;
    int checks = 0;
    int t1, t2;
    reg [31:0] rd;
    reg er;
    always #4 pclk = ~pclk;
    dbtc_top dbtc_top_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hold_mode(hold_mode), .ext_irq_two(ev_two),
        .ext_irq_three(ev_three), .ext_irq_zero(ev_zero), .ext_irq_one(1'b0),
        .port_low_capture(1'b0), .port_high_capture(1'b0), .low_irq_req(low_irq_req),
        .high_irq_req(high_irq_req));
    dbtc_event_src dbtc_event_src_inst (.pclk(pclk), .ext_irq_two(ev_two),
        .ext_irq_three(ev_three), .ext_irq_zero(ev_zero));
    // one apb transfer, held until pready is seen high
    task apb(input bit w, input [15:0] idx, input [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input [15:0] idx, input [7:0] d);
        apb(1'b1, idx, d);
    endtask
    task cmp(input string nm, input [31:0] exp, input [31:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task chk(input [15:0] idx, input [7:0] exp);
        apb(1'b0, idx, 8'h00);
        cmp($sformatf("reg %h", idx), {24'h000000, exp}, rd);
    endtask
    // sampled on the falling edge, clear of the register updates
    task wait_irq(input bit hi, output int t);
        @(negedge pclk);
        while ((hi ? high_irq_req : low_irq_req) !== 1'b1) @(negedge pclk);
        t = cyc;
    endtask
    task per(input bit hi, input [7:0] ctl, input int exp);
        wait_irq(hi, t1);
        wr(`DBTC_IDX_CONTROL, ctl);
        wait_irq(hi, t2);
        cmp("period", exp, t2 - t1);
        wr(`DBTC_IDX_CONTROL, ctl);
    endtask
    task t_reset;
        chk(`DBTC_IDX_CONTROL, 8'h00);
        chk(`DBTC_IDX_PRESCALE, 8'h00);
        chk(`DBTC_IDX_LOW_COUNT, 8'h00);
        chk(`DBTC_IDX_HIGH_COUNT, 8'h00);
        chk(`DBTC_IDX_LOW_MATCH, 8'h00);
        chk(`DBTC_IDX_HIGH_MATCH, 8'h00);
        apb(1'b0, 16'h0001, 8'h00);
        cmp("unmapped error", 1, er);
    endtask
    task t_period;
        wr(`DBTC_IDX_PRESCALE, 8'h02);
        chk(`DBTC_IDX_PRESCALE, 8'h02);
        wr(`DBTC_IDX_LOW_MATCH, 8'h03);
        wr(`DBTC_IDX_HIGH_MATCH, 8'h01);
        wr(`DBTC_IDX_CONTROL, 8'hC1);
        per(1'b0, 8'hC1, 12);
        wr(`DBTC_IDX_CONTROL, 8'hC4);
        per(1'b1, 8'hC4, 6);
    endtask
    task t_events;
        wr(`DBTC_IDX_CONTROL, 8'h00);
        chk(`DBTC_IDX_LOW_COUNT, 8'h00);
        chk(`DBTC_IDX_HIGH_COUNT, 8'h00);
        wr(`DBTC_IDX_LOW_MATCH, 8'h02);
        wr(`DBTC_IDX_INPUT_SELECT, 8'h40);
        wr(`DBTC_IDX_CONTROL, 8'h51);
        dbtc_event_src_inst.pulses(0, 2);
        chk(`DBTC_IDX_LOW_COUNT, 8'h02);
        dbtc_event_src_inst.pulses(2, 1);
        chk(`DBTC_IDX_LOW_CAPTURE, 8'h02);
        cmp("low irq", 0, low_irq_req);
        dbtc_event_src_inst.pulses(0, 1);
        chk(`DBTC_IDX_LOW_COUNT, 8'h00);
        cmp("low irq", 1, low_irq_req);
    endtask
    task t_long;
        wr(`DBTC_IDX_CONTROL, 8'h00);
        wr(`DBTC_IDX_INPUT_SELECT, 8'h00);
        wr(`DBTC_IDX_LOW_MATCH, 8'hFF);
        wr(`DBTC_IDX_HIGH_MATCH, 8'h00);
        wr(`DBTC_IDX_CONTROL, 8'hF5);
        dbtc_event_src_inst.pulses(0, 5);
        dbtc_event_src_inst.pulses(1, 1);
        chk(`DBTC_IDX_LOW_CAPTURE, 8'h05);
        chk(`DBTC_IDX_HIGH_CAPTURE, 8'h00);
        chk(`DBTC_IDX_LOW_CAPTURE2, 8'h02);
        dbtc_event_src_inst.pulses(0, 250);
        cmp("high irq", 0, high_irq_req);
        dbtc_event_src_inst.pulses(0, 1);
        chk(`DBTC_IDX_CONTROL, 8'hFF);
        cmp("high irq", 1, high_irq_req);
    endtask
    // prescaler frozen by hold, then one tick per cycle with limit zero
    task t_hold;
        wr(`DBTC_IDX_CONTROL, 8'h00);
        wr(`DBTC_IDX_PRESCALE, 8'h00);
        hold_mode <= 1'b1;
        wr(`DBTC_IDX_CONTROL, 8'h40);
        repeat (4) @(posedge pclk);
        chk(`DBTC_IDX_LOW_COUNT, 8'h00);
        hold_mode <= 1'b0;
        chk(`DBTC_IDX_LOW_COUNT, 8'h01);
    endtask
    // mode 2: word 0102 with limit 1 repeats every 259 * 2 cycles
    task t_wide;
        wr(`DBTC_IDX_CONTROL, 8'h00);
        wr(`DBTC_IDX_PRESCALE, 8'h01);
        wr(`DBTC_IDX_LOW_MATCH, 8'h02);
        wr(`DBTC_IDX_HIGH_MATCH, 8'h01);
        wr(`DBTC_IDX_CONTROL, 8'hE5);
        per(1'b1, 8'hE5, 518);
    endtask
    task end_of_test;
        if (bad_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // cycle count and hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            end_of_test;
        end
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_period;
        t_events;
        t_long;
        t_hold;
        t_wide;
        end_of_test;
    end
endmodule
bind dbtc_top dbtc_monitor dbtc_monitor_inst (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .low_irq_req(low_irq_req), .high_irq_req(high_irq_req));
